//--- core/ipr_cfg.svh
// ipr_cfg.svh: offsets, field positions, reset values for the priority registers
// assumes: included by bare name from the package and the design file
`ifndef IPR_CFG_SVH
`define IPR_CFG_SVH
// ============================================================
// register byte offsets (one aligned 32-bit word each)
`define IPR_ADDR_W      4
`define IPR_OFS_INT1    4'h0
`define IPR_OFS_INT2    4'h4
`define IPR_OFS_INT3    4'h8
// ============================================================
// field layout
`define IPR_LVL_W       3
`define IPR_INT1_LSB    0
`define IPR_INT2_LSB    4
`define IPR_INT3_LSB    4
`define IPR_REG_W       16
`define IPR_DATA_W      32
// ============================================================
// values
`define IPR_LVL_RST     3'h4
`define IPR_LVL_OFF     3'h0
`define IPR_LVL_MIN     3'h1
`define IPR_LVL_MAX     3'h7
`define IPR_NSRC        3
`define IPR_RD_ERR      32'h0000_0000
`endif

//--- core/ipr_pkg.sv
// ipr_pkg.sv: types shared by the priority register block
// assumes: ipr_cfg.svh on the include path
`default_nettype none
`include "ipr_cfg.svh"
package ipr_pkg;
  // ============================================================
  // level of one source, 0 means disabled
  typedef logic [`IPR_LVL_W-1:0] ipr_lvl_t;
  // ============================================================
  // avalon-mm request from the bus master
  typedef struct packed {
    logic [`IPR_ADDR_W-1:0] address;
    logic                   read;
    logic                   write;
    logic [`IPR_DATA_W-1:0] writedata;
    logic [3:0]             byteenable;
  } ipr_req_s;
  // per-source decoded output toward arbitration
  typedef struct packed {
    logic     active;
    ipr_lvl_t level;
  } ipr_src_s;
endpackage : ipr_pkg
`default_nettype wire

//--- core/ipr_regs.sv
// ipr_regs.sv: priority fields of three external interrupt sources, avalon-mm slave
// assumes: single clock ref_clk, async active-low reset, master holds request until waitrequest low
//
// Overview of operation
// - code 111 gives level 7, intermediate codes give matching levels
// - code 001 gives level 1, lowest level still requesting service
// - code 000 disables source, never requests whatever its flag
// - unimplemented register bits always read back as zero
// - every priority field resets to 100, level 4; other bits zero
// - first source field sits in bits 2..0 of its register
// - second source field sits in bits 6..4 of its register
// - third source field sits in bits 6..4 of its register
`timescale 1ns/10ps
`default_nettype none
`include "ipr_cfg.svh"
module ipr_regs (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  // avalon-mm slave
  input  wire logic [`IPR_ADDR_W-1:0]       avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [`IPR_DATA_W-1:0]       avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [`IPR_DATA_W-1:0]       avs_readdata,
  output logic                              avs_waitrequest,
  // interrupt flags in, prioritised requests out
  input  wire logic [`IPR_NSRC-1:0]         src_flag,
  output logic      [`IPR_NSRC-1:0]         src_request,
  output logic      [`IPR_NSRC*`IPR_LVL_W-1:0] src_level
);
  // ============================================================
  // bus decode
  ipr_pkg::ipr_lvl_t lvl_r   [`IPR_NSRC];
  ipr_pkg::ipr_lvl_t lvl_nxt [`IPR_NSRC];
  logic              ack_r;
  logic [`IPR_DATA_W-1:0] rdata_r;
  logic [`IPR_DATA_W-1:0] rdata_nxt;
  wire  logic        req     = avs_read | avs_write;
  wire  logic        sel1    = (avs_address == `IPR_OFS_INT1);
  wire  logic        sel2    = (avs_address == `IPR_OFS_INT2);
  wire  logic        sel3    = (avs_address == `IPR_OFS_INT3);
  // write lands at the accepting edge only, the same edge at which the master lets go
  wire  logic        do_wr   = avs_write & ack_r & avs_byteenable[0];
  wire  logic [`IPR_NSRC-1:0] wr_hit = {do_wr & sel3, do_wr & sel2, do_wr & sel1};
  // one wait state: answer on the second cycle of each request
  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata    = rdata_r;

  // place a level into a zero word at a bit position
  function automatic logic [`IPR_DATA_W-1:0] place(input ipr_pkg::ipr_lvl_t v, input int lsb);
    logic [`IPR_DATA_W-1:0] w;
    w = '0;
    w[lsb +: `IPR_LVL_W] = v;
    return w;
  endfunction : place

  // only implemented bits are driven, the rest are zero
  always_comb
  begin
    rdata_nxt = '0;
    if (sel1)
      rdata_nxt = place(lvl_r[0], `IPR_INT1_LSB);
    else if (sel2)
      rdata_nxt = place(lvl_r[1], `IPR_INT2_LSB);
    else if (sel3)
      rdata_nxt = place(lvl_r[2], `IPR_INT3_LSB);
    else
      rdata_nxt = `IPR_RD_ERR;
  end

  always_comb
  begin
    lvl_nxt[0] = wr_hit[0] ? avs_writedata[`IPR_INT1_LSB +: `IPR_LVL_W] : lvl_r[0];
    lvl_nxt[1] = wr_hit[1] ? avs_writedata[`IPR_INT2_LSB +: `IPR_LVL_W] : lvl_r[1];
    lvl_nxt[2] = wr_hit[2] ? avs_writedata[`IPR_INT3_LSB +: `IPR_LVL_W] : lvl_r[2];
  end

  // ============================================================
  // registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_r   <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      ack_r   <= req & ~ack_r;
      rdata_r <= (avs_read & ~ack_r) ? rdata_nxt : rdata_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `IPR_NSRC; g++)
    begin : g_src
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          lvl_r[g] <= `IPR_LVL_RST;
        else
          lvl_r[g] <= lvl_nxt[g];
      end
      // level passes straight through; zero masks the request
      assign src_level[g*`IPR_LVL_W +: `IPR_LVL_W] = lvl_r[g];
      assign src_request[g] = src_flag[g] & (lvl_r[g] != `IPR_LVL_OFF);
    end
  endgenerate

  // ============================================================
  // checks: bus access
  wait_first_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(req) |-> avs_waitrequest)
    else $error("new request not held off");

  wait_one_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(req) |=> !avs_waitrequest)
    else $error("answer late");

  read_unmap_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (avs_read && !avs_waitrequest && !(sel1 || sel2 || sel3)) |-> (avs_readdata == '0))
    else $error("unmapped read nonzero");

  byte_skip_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (avs_write && !avs_waitrequest && !avs_byteenable[0]) |=> $stable(src_level))
    else $error("write without low byte changed a field");

  // ============================================================
  // checks: fields
  read_int1_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (avs_read && !avs_waitrequest && sel1) |-> (avs_readdata[`IPR_INT1_LSB +: `IPR_LVL_W] == lvl_r[0]))
    else $error("field 1 read wrong");

  read_int2_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (avs_read && !avs_waitrequest && sel2) |-> (avs_readdata[`IPR_INT2_LSB +: `IPR_LVL_W] == lvl_r[1]))
    else $error("field 2 read wrong");

  read_int3_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (avs_read && !avs_waitrequest && sel3) |-> (avs_readdata[`IPR_INT3_LSB +: `IPR_LVL_W] == lvl_r[2]))
    else $error("field 3 read wrong");

  read_zero1_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (avs_read && !avs_waitrequest && sel1) |-> (avs_readdata[`IPR_DATA_W-1:`IPR_INT1_LSB+`IPR_LVL_W] == '0))
    else $error("unimplemented bits of register 1 nonzero");

  read_zero2_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n) (avs_read && !avs_waitrequest && sel2) |->
    (avs_readdata[`IPR_DATA_W-1:`IPR_INT2_LSB+`IPR_LVL_W] == '0 && avs_readdata[`IPR_INT2_LSB-1:0] == '0))
    else $error("unimplemented bits of register 2 nonzero");

  read_zero_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n) (avs_read && !avs_waitrequest && sel3) |->
    (avs_readdata[`IPR_DATA_W-1:`IPR_INT3_LSB+`IPR_LVL_W] == '0 && avs_readdata[`IPR_INT3_LSB-1:0] == '0))
    else $error("unimplemented bits of register 3 nonzero");

  write_one_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_hit[0] |=> (src_level[`IPR_LVL_W-1:0] == $past(avs_writedata[`IPR_INT1_LSB +: `IPR_LVL_W])))
    else $error("field 1 write not applied");

  write_next_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_hit[1] |=> (lvl_r[1] == $past(avs_writedata[`IPR_INT2_LSB +: `IPR_LVL_W])))
    else $error("field 2 write not applied next cycle");

  write_three_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_hit[2] |=> (src_level[2*`IPR_LVL_W +: `IPR_LVL_W] == $past(avs_writedata[`IPR_INT3_LSB +: `IPR_LVL_W])))
    else $error("field 3 write not applied");

  level_pass_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_hit[0] && avs_writedata[`IPR_INT1_LSB +: `IPR_LVL_W] == `IPR_LVL_MAX) |=> (src_level[`IPR_LVL_W-1:0] == `IPR_LVL_MAX))
    else $error("code 111 did not give the top level");

  reset_level_a: assert property (
    @(posedge ref_clk)
    $rose(rst_n) |-> (lvl_r[0] == `IPR_LVL_RST && lvl_r[1] == `IPR_LVL_RST && lvl_r[2] == `IPR_LVL_RST))
    else $error("reset level wrong");

  // ============================================================
  // checks: arbitration, per source
  generate
    for (g = 0; g < `IPR_NSRC; g++)
    begin : g_chk
      disable_off_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (lvl_r[g] == `IPR_LVL_OFF) |-> !src_request[g])
        else $error("disabled source requested");

      low_level_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (src_flag[g] && lvl_r[g] == `IPR_LVL_MIN) |-> src_request[g])
        else $error("level 1 source not requesting");

      req_on_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (src_flag[g] && lvl_r[g] != `IPR_LVL_OFF) |-> src_request[g])
        else $error("enabled flagged source not requesting");

      hold_level_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !wr_hit[g] |=> $stable(lvl_r[g]))
        else $error("level changed without a write");
    end
  endgenerate

  // ============================================================
  // coverage
  cov_wr_c: cover property (@(posedge ref_clk) do_wr && sel1);
  cov_rd_c: cover property (@(posedge ref_clk) avs_read && !avs_waitrequest && sel2);
  cov_off_c: cover property (@(posedge ref_clk) src_flag[2] && lvl_r[2] == `IPR_LVL_OFF);
  cov_lvl1_c: cover property (@(posedge ref_clk) src_request[1] && lvl_r[1] == `IPR_LVL_MIN);
  cov_unmap_c: cover property (@(posedge ref_clk) avs_read && !avs_waitrequest && !(sel1 || sel2 || sel3));
endmodule : ipr_regs
`default_nettype wire

//--- testbench/ipr_core_model.sv
// ipr_core_model.sv: core side, takes the highest pending level
// assumes: requests and levels come straight from ipr_regs
`timescale 1ns/10ps
`default_nettype none
module ipr_core_model (
  // from the priority block
  input  wire logic [2:0] src_request,
  input  wire logic [8:0] src_level,
  // level taken for service
  output logic      [2:0] take_lvl
);
  // only raised requests count, so a disabled source is never taken
  always_comb
  begin
    take_lvl = 3'h0;
    for (int i = 0; i < 3; i++)
      if (src_request[i] && src_level[i*3+:3] > take_lvl) take_lvl = src_level[i*3+:3];
  end
endmodule : ipr_core_model
`default_nettype wire

//--- testbench/tb_top.sv
// tb_top.sv: self-checking bench for ipr_regs
// assumes: ipr_cfg.svh on the include path, one wait state per access
`timescale 1ns/10ps
`default_nettype none
`include "ipr_cfg.svh"
module tb_top;
  // ========
  // stimulus and outputs
  logic        ref_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'h1;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdq[$];
  logic [2:0]  src_flag = 3'h0, src_request, take_lvl, lvl[3];
  logic [8:0]  src_level;
  int          error_cnt = 0, total_checks = 0;
  localparam logic [3:0] OFS [3] = '{`IPR_OFS_INT1, `IPR_OFS_INT2, `IPR_OFS_INT3};
  localparam int         LSB [3] = '{0, 4, 4};
  always #5 ref_clk = ~ref_clk;
  ipr_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_flag(src_flag),
    .src_request(src_request), .src_level(src_level));
  ipr_core_model core (.src_request(src_request), .src_level(src_level), .take_lvl(take_lvl));
  // ========
  // tasks
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_arb(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t arb got %h exp %h", $time, got, exp);
    end
  endtask : cmp_arb
  task automatic cmp_take(input logic [2:0] got, input logic [2:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t take got %h exp %h", $time, got, exp);
    end
  endtask : cmp_take
  // highest level among flagged sources wins; level 0 never wins
  function automatic logic [2:0] exp_take();
    logic [2:0] e;
    e = 3'h0;
    for (int i = 0; i < 3; i++)
      if (src_flag[i] && lvl[i] > e) e = lvl[i];
    return e;
  endfunction : exp_take
  // request held until the edge that sees waitrequest low, released after it
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge ref_clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
    begin
      error_cnt++;
      end_sim();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    rdq.push_back(exp);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask : rd
  // one field written, then levels, requests and the core's pick checked mid-cycle
  task automatic set_lvl(input int i, input logic [2:0] v, input logic [31:0] junk);
    logic [31:0] d;
    d = junk;
    d[LSB[i] +: 3] = v;
    lvl[i] = v;
    bus(1'b1, OFS[i], d, 4'h1);
    @(negedge ref_clk);
    cmp_arb(src_level, {lvl[2], lvl[1], lvl[0]});
    cmp_arb(9'(src_request), 9'(src_flag & {|lvl[2], |lvl[1], |lvl[0]}));
    cmp_take(take_lvl, exp_take());
    @(posedge ref_clk);
  endtask : set_lvl
  // read data taken only at the accepting edge
  always @(posedge ref_clk)
    if (avs_read && avs_waitrequest === 1'b0) cmp(avs_readdata, rdq.pop_front());
  // ========
  // main sequence
  initial
  begin
    void'($urandom(32'h8bb5));
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) rd(OFS[i], 32'h4 << LSB[i]);
    $display("test reset values done");
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, OFS[i], 32'hffff_ffff, 4'hf);
      rd(OFS[i], 32'h7 << LSB[i]);
      lvl[i] = 3'h7;
    end
    bus(1'b1, OFS[0], 32'h0, 4'he);
    rd(OFS[0], 32'h7);
    rd(4'hc, 32'h0);
    $display("test access done");
    // every code on every source, random flags and random unused bits
    for (int c = 0; c < 8; c++)
      for (int i = 0; i < 3; i++)
      begin
        src_flag <= 3'($urandom);
        set_lvl(i, 3'(c ^ i), $urandom);
      end
    $display("test levels done");
    // all flags up: top level wins, level 1 is still served, level 0 never
    src_flag <= 3'h7;
    set_lvl(0, 3'h1, 32'h0);
    set_lvl(1, 3'h0, 32'h0);
    set_lvl(2, 3'h7, 32'h0);
    set_lvl(2, 3'h1, 32'h0);
    set_lvl(0, 3'h0, 32'h0);
    $display("test arbitration done");
    // reset in mid-run brings every field back to level 4
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) lvl[i] = `IPR_LVL_RST;
    @(negedge ref_clk);
    cmp_arb(src_level, {lvl[2], lvl[1], lvl[0]});
    cmp_arb(9'(src_request), 9'(src_flag));
    cmp_take(take_lvl, exp_take());
    for (int i = 0; i < 3; i++) rd(OFS[i], 32'h4 << LSB[i]);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
